// [src/tos_crc6.v]
// serial crc-6 accumulator over one superframe
`timescale 1ns/1ns
module tos_crc6 (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       bit_en,
  input  wire       bit_in,
  input  wire       sf_last,
  output reg  [5:0] crc_out
);
`include "tos_defs.vh"

  reg  [5:0] acc_reg;
  wire       fb;
  wire [5:0] acc_next;

  assign fb       = bit_in ^ acc_reg[5];
  assign acc_next = {acc_reg[4:0], 1'b0} ^ (fb ? `TOS_CRC_POLY : 6'h00);

  // the finished check is held for the whole following superframe
  always @(posedge aclk) begin
    if (!aresetn) begin
      acc_reg <= 6'h00;
      crc_out <= 6'h00;
    end else if (bit_en) begin
      if (sf_last) begin
        acc_reg <= 6'h00;
        crc_out <= acc_next;
      end else begin
        acc_reg <= acc_next;
      end
    end
  end

endmodule // tos_crc6

// [src/tos_defs.vh]
// register map, field layout and reset values of the overhead source select
`ifndef TOS_DEFS_VH
`define TOS_DEFS_VH

// register indices; byte address is four times the index
`define TOS_IDX_CFG        12'h108
`define TOS_IDX_SYNC_MUX   12'h109
`define TOS_IDX_LINK_SEL   12'h10a
`define TOS_IDX_STATUS     12'h110

// tx_frame_config fields
`define TOS_CFG_CRC_MF_BIT 0
`define TOS_CFG_SLC_BIT    1
`define TOS_CFG_RESET      8'h01
`define TOS_CFG_MASK       8'h03

// sync_mux_control fields
`define TOS_MUX_FBS_BIT    0
`define TOS_MUX_CRC_BIT    1
`define TOS_MUX_RESET      8'h00
`define TOS_MUX_MASK       8'h03

// tx_signaling_link_select fields
`define TOS_TSD_DE_LSB     2
`define TOS_TSD_BW_LSB     4
`define TOS_TSD_RESET      8'h00
`define TOS_TSD_MASK       8'h3c

// link bandwidth codes
`define TOS_BW_ALL         2'b00
`define TOS_BW_ODD         2'b01
`define TOS_BW_EVEN        2'b10

// d/e time slot source codes
`define TOS_DE_SERIAL      2'b00
`define TOS_DE_LAPD        2'b01
`define TOS_DE_FRAC        2'b11

// frame geometry
`define TOS_BITS_PER_FRAME 8'd193
`define TOS_ESF_FRAMES     5'd24
`define TOS_SLC_FRAMES     5'd12
`define TOS_FPS_PATTERN    6'b001011
`define TOS_CRC_POLY       6'h03

// axi responses
`define TOS_RESP_OKAY      2'b00
`define TOS_RESP_SLVERR    2'b10

`endif

// [src/tos_overhead_select.v]
// transmit t1 overhead source selection with axi4-lite registers
// Summary of operation
// - crc source 0: compute crc-6 internally and insert it
// - crc source 1: crc-6 positions copied unchanged from serial input
// - crc source ignored while crc multiframe alignment is off
// - framing source 0: framing bits generated internally
// - framing source 1: framing bits copied from serial input
// - bandwidth 00: link bit in every odd frame, 4 khz channel
// - bandwidth 01: link bits only on frames 1, 5, 9 .. 21, 2 khz
// - bandwidth 10: link bits only on frames 3, 7, 11 .. 23, 2 khz
// - bandwidth applies only in esf; slc format fixed at 4 khz
// - d/e source 00: d/e slots from serial input
// - d/e source 01: d/e slots from internal lapd controller
// - d/e source 11: d/e slots from fractional pin; 10 reserved
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module tos_overhead_select #(
  parameter DE_SLOT = 24
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        tx_bit_strobe,
  input  wire        tx_serial_in,
  input  wire        lapd_bit_in,
  input  wire        tx_fractional_in,
  input  wire        link_bit_in,
  output wire        link_bit_req,
  output wire        lapd_bit_req,
  output wire        frac_bit_req,
  output reg         tx_line_out,
  output reg         tx_line_valid,
  output reg  [4:0]  frame_num,
  output reg         sf_start
);
`include "tos_defs.vh"

  // ---------------- register file ----------------
  reg  [7:0]  cfg_reg;
  reg  [7:0]  mux_reg;
  reg  [7:0]  tsd_reg;
  reg  [11:0] awaddr_reg;
  reg         aw_held_reg;
  reg  [7:0]  wdata_reg;
  reg         wstrb0_reg;
  reg         w_held_reg;

  // byte address to register index, or all ones when not word aligned
  function [11:0] reg_index;
    input [11:0] addr;
    begin
      if (addr[1:0] != 2'b00)
        reg_index = 12'hfff;
      else
        reg_index = {2'b00, addr[11:2]};
    end
  endfunction

  function mapped;
    input [11:0] idx;
    begin
      mapped = (idx == `TOS_IDX_CFG) || (idx == `TOS_IDX_SYNC_MUX) ||
               (idx == `TOS_IDX_LINK_SEL) || (idx == `TOS_IDX_STATUS);
    end
  endfunction

  wire        wr_go;
  wire [11:0] wr_idx;
  wire [11:0] rd_idx;

  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go         = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_idx        = reg_index(awaddr_reg);
  assign rd_idx        = reg_index(s_axi_araddr);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg  <= 1'b0;
      w_held_reg   <= 1'b0;
      awaddr_reg   <= 12'h000;
      wdata_reg    <= 8'h00;
      wstrb0_reg   <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `TOS_RESP_OKAY;
      cfg_reg      <= `TOS_CFG_RESET;
      mux_reg      <= `TOS_MUX_RESET;
      tsd_reg      <= `TOS_TSD_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_reg  <= s_axi_awaddr;
        aw_held_reg <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_reg  <= s_axi_wdata[7:0];
        wstrb0_reg <= s_axi_wstrb[0];
        w_held_reg <= 1'b1;
      end
      if (wr_go) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(wr_idx) ? `TOS_RESP_OKAY : `TOS_RESP_SLVERR;
        if (wstrb0_reg) begin
          case (wr_idx)
            `TOS_IDX_CFG:      cfg_reg <= wdata_reg & `TOS_CFG_MASK;
            `TOS_IDX_SYNC_MUX: mux_reg <= wdata_reg & `TOS_MUX_MASK;
            `TOS_IDX_LINK_SEL: tsd_reg <= wdata_reg & `TOS_TSD_MASK;
            // status is read only; a write is answered but ignored
            `TOS_IDX_STATUS:   cfg_reg <= cfg_reg;
            default:           cfg_reg <= cfg_reg;
          endcase
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `TOS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= mapped(rd_idx) ? `TOS_RESP_OKAY : `TOS_RESP_SLVERR;
      case (rd_idx)
        `TOS_IDX_CFG:      s_axi_rdata <= {24'h000000, cfg_reg};
        `TOS_IDX_SYNC_MUX: s_axi_rdata <= {24'h000000, mux_reg};
        `TOS_IDX_LINK_SEL: s_axi_rdata <= {24'h000000, tsd_reg};
        `TOS_IDX_STATUS:   s_axi_rdata <= {24'h000000, 3'b000, frame_num};
        default:           s_axi_rdata <= 32'h00000000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------- configuration fields ----------------
  wire       crc_mf_en = cfg_reg[`TOS_CFG_CRC_MF_BIT];
  wire       slc_mode  = cfg_reg[`TOS_CFG_SLC_BIT];
  wire       fbit_ext  = mux_reg[`TOS_MUX_FBS_BIT];
  wire       crc_ext   = mux_reg[`TOS_MUX_CRC_BIT];
  wire [1:0] de_sel    = tsd_reg[`TOS_TSD_DE_LSB +: 2];
  wire [1:0] bw_sel    = tsd_reg[`TOS_TSD_BW_LSB +: 2];

  // check bits follow the serial input only with multiframe alignment on
  wire       crc_serial = crc_mf_en && crc_ext;

  // ---------------- frame position ----------------
  reg  [7:0] bit_cnt;
  wire [4:0] sf_len    = slc_mode ? `TOS_SLC_FRAMES : `TOS_ESF_FRAMES;
  wire       frame_end = (bit_cnt == `TOS_BITS_PER_FRAME - 8'd1);
  wire       sf_end    = frame_end && (frame_num >= sf_len);

  always @(posedge aclk) begin
    if (!aresetn) begin
      bit_cnt   <= 8'h00;
      frame_num <= 5'h01;
      sf_start  <= 1'b0;
    end else begin
      sf_start <= tx_bit_strobe && sf_end;
      if (tx_bit_strobe) begin
        if (frame_end) begin
          bit_cnt   <= 8'h00;
          frame_num <= sf_end ? 5'h01 : frame_num + 5'h01;
        end else begin
          bit_cnt <= bit_cnt + 8'h01;
        end
      end
    end
  end

  // bit position within a frame falls inside time slot n (1..24)
  function in_slot;
    input [7:0] pos;
    input [7:0] slot;
    begin
      in_slot = (pos >= ((slot - 8'h01) << 3) + 8'h01) &&
                (pos <= (slot << 3));
    end
  endfunction

  // framing pattern bit sent in pattern frame g (frames 4, 8 .. 24)
  function fps_bit;
    input [2:0] g;
    reg   [5:0] pat;
    begin
      pat = `TOS_FPS_PATTERN;
      case (g)
        3'd1:    fps_bit = pat[5];
        3'd2:    fps_bit = pat[4];
        3'd3:    fps_bit = pat[3];
        3'd4:    fps_bit = pat[2];
        3'd5:    fps_bit = pat[1];
        3'd6:    fps_bit = pat[0];
        default: fps_bit = 1'b1;
      endcase
    end
  endfunction

  // check bit sent in check frame g (0..5), first bit first
  function crc_bit;
    input [5:0] c;
    input [2:0] g;
    begin
      case (g)
        3'd0:    crc_bit = c[5];
        3'd1:    crc_bit = c[4];
        3'd2:    crc_bit = c[3];
        3'd3:    crc_bit = c[2];
        3'd4:    crc_bit = c[1];
        3'd5:    crc_bit = c[0];
        default: crc_bit = 1'b1;
      endcase
    end
  endfunction

  // ---------------- overhead selection ----------------
  wire [5:0] crc_int;
  wire       f_pos    = (bit_cnt == 8'h00);
  wire       odd_fr   = frame_num[0];
  wire [1:0] fr_mod4  = frame_num[1:0];
  wire [2:0] grp      = frame_num[4:2];
  // even esf frames: 2 mod 4 carry check bits, 0 mod 4 the pattern
  wire       crc_fr   = (fr_mod4 == 2'b10);
  wire       de_pos   = !f_pos && in_slot(bit_cnt, DE_SLOT[7:0]);

  // esf data link occupancy of odd frames
  reg        dl_used;
  always @* begin
    dl_used = 1'b0;
    case (bw_sel)
      `TOS_BW_ALL:  dl_used = 1'b1;
      `TOS_BW_ODD:  dl_used = (fr_mod4 == 2'b01);
      `TOS_BW_EVEN: dl_used = (fr_mod4 == 2'b11);
      // reserved code 11 carries no link bits
      default:      dl_used = 1'b0;
    endcase
  end

  reg        out_bit;
  reg        want_link;
  reg        want_lapd;
  reg        want_frac;
  reg        crc_feed;
  always @* begin
    out_bit   = tx_serial_in;
    want_link = 1'b0;
    want_lapd = 1'b0;
    want_frac = 1'b0;
    crc_feed  = tx_serial_in;
    if (f_pos && slc_mode) begin
      crc_feed = 1'b1;
      if (odd_fr) begin
        // alternating terminal framing pattern starting at one
        out_bit = fbit_ext ? tx_serial_in : !frame_num[1];
      end else begin
        want_link = 1'b1;
        out_bit   = link_bit_in;
      end
    end else if (f_pos) begin
      crc_feed = 1'b1;
      if (odd_fr) begin
        // idle link positions carry ones
        want_link = dl_used;
        out_bit   = dl_used ? link_bit_in : 1'b1;
      end else if (crc_fr) begin
        // first check bit goes out in frame 2, last in frame 22
        if (crc_serial)
          out_bit = tx_serial_in;
        else
          out_bit = crc_bit(crc_int, grp);
      end else begin
        if (fbit_ext)
          out_bit = tx_serial_in;
        else
          out_bit = fps_bit(grp);
      end
    end else if (de_pos) begin
      case (de_sel)
        `TOS_DE_LAPD: begin
          want_lapd = 1'b1;
          out_bit   = lapd_bit_in;
        end
        `TOS_DE_FRAC: begin
          want_frac = 1'b1;
          out_bit   = tx_fractional_in;
        end
        `TOS_DE_SERIAL: out_bit = tx_serial_in;
        // reserved code falls back to the serial input
        default:      out_bit = tx_serial_in;
      endcase
      crc_feed = out_bit;
    end
  end

  assign link_bit_req = tx_bit_strobe && want_link;
  assign lapd_bit_req = tx_bit_strobe && want_lapd;
  assign frac_bit_req = tx_bit_strobe && want_frac;

  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_line_out   <= 1'b1;
      tx_line_valid <= 1'b0;
    end else begin
      tx_line_valid <= tx_bit_strobe;
      if (tx_bit_strobe)
        tx_line_out <= out_bit;
    end
  end

  // check covers the payload of the previous superframe, f bits as ones
  tos_crc6 u_crc6 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .bit_en  (tx_bit_strobe),
    .bit_in  (crc_feed),
    .sf_last (sf_end),
    .crc_out (crc_int)
  );

endmodule // tos_overhead_select

// [test/tos_overhead_select_asserts.sv]
// assertions on the overhead select bit stream ports
`timescale 1ns/1ns
module tos_chk (
  input logic       aclk,
  input logic       aresetn,
  input logic       tx_bit_strobe,
  input logic       link_bit_in,
  input logic       lapd_bit_in,
  input logic       tx_fractional_in,
  input logic       link_bit_req,
  input logic       lapd_bit_req,
  input logic       frac_bit_req,
  input logic       tx_line_out,
  input logic       tx_line_valid,
  input logic [4:0] frame_num,
  input logic       sf_start
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_link_take;
    tx_bit_strobe && link_bit_req;
  endsequence
  sequence s_lapd_take;
    tx_bit_strobe && lapd_bit_req;
  endsequence
  a_link_value: assert property (
    s_link_take |=> tx_line_out == $past(link_bit_in)) else $error("link bit");
  a_lapd_value: assert property (
    s_lapd_take |=> tx_line_out == $past(lapd_bit_in)) else $error("lapd bit");
  a_frac_value: assert property (
    frac_bit_req |=> tx_line_out == $past(tx_fractional_in))
    else $error("frac bit");
  a_one_source: assert property (
    $onehot0({link_bit_req, lapd_bit_req, frac_bit_req})) else $error("two");
  a_req_strobe: assert property (
    (link_bit_req || lapd_bit_req || frac_bit_req) |-> tx_bit_strobe)
    else $error("req without strobe");
  a_valid_pulse: assert property (
    tx_line_valid == $past(tx_bit_strobe)) else $error("valid timing");
  a_line_hold: assert property (
    !tx_bit_strobe |=> $stable(tx_line_out)) else $error("line moved");
  a_frame_range: assert property (
    frame_num >= 5'h01 && frame_num <= 5'h18) else $error("frame range");
  a_sf_wrap: assert property (
    sf_start == ($past(tx_bit_strobe) && frame_num == 5'h01 &&
                 $past(frame_num) != 5'h01)) else $error("superframe pulse");
endmodule // tos_chk

// [test/tos_overhead_select_bench.sv]
// bench for the transmit overhead source select
`timescale 1ns/1ns
module tos_overhead_select_bench;
  logic        aclk, aresetn, run, slc, obs, fb;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, tx_bit_strobe, tx_serial_in;
  logic        lapd_bit_in, tx_fractional_in, link_bit_in, link_bit_req;
  logic        lapd_bit_req, frac_bit_req, tx_line_out, tx_line_valid;
  logic [7:0]  pos, p_pos;
  logic [4:0]  frm, p_frm;
  logic [23:0] lmask, fmask;
  logic [5:0]  crc, crc_new, crc_old;
  int          mismatches, compares, lapd_n, frac_n;
  tos_overhead_select tos_overhead_select_i (.*, .s_axi_wstrb(4'hf),
    .frame_num(), .sf_start());
  tos_term_model tos_term_model_i (.*);
  initial begin
    aclk = 0;
    forever #50 aclk = ~aclk;
  end
  task automatic chk(input string n, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic axw(input logic [11:0] a, input logic [7:0] d, e);
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 0;
    chk("bresp", s_axi_bresp, e);
  endtask
  task automatic axr(input logic [11:0] a, input logic [7:0] d, e);
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 0;
    chk("rdata", s_axi_rdata, d);
    chk("rresp", s_axi_rresp, e);
  endtask
  always @(posedge aclk) if (obs) begin
    if (tx_line_valid) begin
      if (p_pos == 0) fmask[p_frm-1] = tx_line_out;
      fb = crc[5] ^ (p_pos == 0 || tx_line_out);
      crc = {crc[4:0], 1'b0} ^ {4'h0, fb, fb};
      if (p_pos == 192 && p_frm == (slc ? 12 : 24)) begin
        crc_old = crc_new; crc_new = crc; crc = 0;
      end
    end
    if (tx_bit_strobe) begin
      p_pos = pos; p_frm = frm;
      if (link_bit_req) lmask[frm-1] = 1;
      lapd_n += lapd_bit_req; frac_n += frac_bit_req;
    end
  end
  task automatic run_sf(input logic [7:0] c, m, t, input logic s, int n);
    axw(12'h420, c, 0); axw(12'h424, m, 0); axw(12'h428, t, 0);
    @(posedge aclk);
    lmask = 0; fmask = 0; crc = 0; lapd_n = 0; frac_n = 0;
    slc <= s; obs = 1; run <= 1;
    repeat (n * (s ? 12 : 24) * 193 - 4) @(posedge aclk);
    run <= 0;
    repeat (8) @(posedge aclk);
    obs = 0;
  endtask
  function automatic logic [5:0] crc_seen();
    return {fmask[1], fmask[5], fmask[9], fmask[13], fmask[17], fmask[21]};
  endfunction
  task automatic t_regs;
    axr(12'h420, 8'h01, 0);
    axr(12'h440, 8'h01, 0);
    axr(12'h424, 8'h00, 0);
    axr(12'h428, 8'h00, 0);
    axw(12'h428, 8'hff, 0); axr(12'h428, 8'h3c, 0);
    axw(12'h424, 8'hff, 0); axr(12'h424, 8'h03, 0);
    axw(12'h7fc, 8'h01, 2); axr(12'h7fc, 8'h00, 2);
  endtask
  task automatic t_every_frame;
    run_sf(8'h01, 8'h03, 8'h04, 0, 1);
    chk("lmask", lmask, 24'h555555);
    chk("lapd", lapd_n, 192);
    chk("fmask", fmask, 24'hffffff);
  endtask
  task automatic t_odd_frac;
    run_sf(8'h01, 8'h01, 8'h1c, 0, 2);
    chk("lmask", lmask, 24'h111111);
    chk("frac", frac_n, 384);
    chk("fmask", fmask | 24'h222222, 24'hffffff);
    chk("crc", crc_seen(), crc_old);
  endtask
  task automatic t_even_align_off;
    run_sf(8'h00, 8'h03, 8'h28, 0, 2);
    chk("lmask", lmask, 24'h444444);
    chk("de", lapd_n + frac_n, 0);
    chk("crc", crc_seen(), crc_old);
  endtask
  task automatic t_internal_f;
    run_sf(8'h01, 8'h00, 8'h00, 0, 1);
    chk("fps", fmask & 24'h888888, 24'h880800);
    chk("de", lapd_n + frac_n, 0);
  endtask
  task automatic t_slc;
    run_sf(8'h03, 8'h00, 8'h30, 1, 1);
    chk("lmask", lmask, 24'h000aaa);
    chk("fmask", fmask, 24'h000bbb);
  endtask
  task automatic finish_test;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge aclk);
    mismatches++;
    finish_test;
  end
  initial begin
    {aresetn, run, slc, obs, s_axi_awvalid, s_axi_wvalid} = 0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    t_regs;
    t_every_frame;
    t_odd_frac;
    t_even_align_off;
    t_internal_f;
    t_slc;
    finish_test;
  end
endmodule // tos_overhead_select_bench
bind tos_overhead_select tos_chk tos_chk_i (.*);

// [test/tos_term_model.sv]
// system-side terminal model feeding serial and overhead source bits
`timescale 1ns/1ns
module tos_term_model (
  input  logic       aclk,
  input  logic       aresetn,
  input  logic       run,
  input  logic       slc,
  output logic       tx_bit_strobe,
  output logic       tx_serial_in,
  output logic       lapd_bit_in,
  output logic       tx_fractional_in,
  output logic       link_bit_in,
  output logic [7:0] pos,
  output logic [4:0] frm
);
  // whole superframes only; bit timing stands still between them
  assign tx_bit_strobe    = aresetn && (run || pos != 8'h00 || frm != 5'h01);
  assign tx_serial_in     = 1'b1;
  assign lapd_bit_in      = pos[0];
  assign tx_fractional_in = pos[1];
  assign link_bit_in      = 1'b1;
  always @(posedge aclk) begin
    if (!aresetn) begin
      pos <= 8'h00;
      frm <= 5'h01;
    end else if (tx_bit_strobe) begin
      pos <= (pos == 8'hc0) ? 8'h00 : pos + 8'h01;
      if (pos == 8'hc0)
        frm <= (frm == (slc ? 5'h0c : 5'h18)) ? 5'h01 : frm + 5'h01;
    end
  end
endmodule // tos_term_model
